// *** common/tlem_regs.svh ***
// Purpose: offsets, fields and reset values of the travel limit monitor
// Assumes: apb with 32-bit words, byte addresses below
// Notes: Operation list follows
// Operation
// (R1) flag software limit when command enters region
// (R2) software check uses commanded, not measured, position
// (R3) command is measured plus error; overshoot ignored
// (R4) hardware limit detection works with servo off
// (R5) hardware check follows real sensor position
// (R6) one direction output opens on software entry
// (R7) scale direction setting swaps the direction outputs
// (R8) limit inputs default to normally closed
// (R9) unconnected limit input raises hardware warning
// (R10) exit-direction motion stays allowed during limit
// (R11) hardware warning latched until opposite motion
// (R12) hand turning opposite with servo off releases
// (R13) emergency stop: alarm, servo off, dynamic brake
// (R14) emergency alarm clears when input released
// (R15) emergency input defaults normally closed
// (R16) direction outputs closed outside software region
`ifndef TLEM_REGS_SVH
`define TLEM_REGS_SVH
`define TLEM_A_CTRL      8'h00
`define TLEM_A_STATUS    8'h04
`define TLEM_A_IRQ_STAT  8'h08
`define TLEM_A_IRQ_MASK  8'h0C
`define TLEM_A_SW_PLUS   8'h10
`define TLEM_A_SW_MINUS  8'h14
`define TLEM_A_CMD_POS   8'h18
`define TLEM_C_SDIR      0
`define TLEM_C_SERVO     1
`define TLEM_C_PPOL      2
`define TLEM_C_MPOL      3
`define TLEM_C_EPOL      4
`define TLEM_CTRL_W      5
`define TLEM_CTRL_RST    5'h00
`define TLEM_S_F2        0
`define TLEM_S_F3        1
`define TLEM_S_F4        2
`define TLEM_S_POUT      3
`define TLEM_S_MOUT      4
`define TLEM_S_SERVO     5
`define TLEM_S_HWP       6
`define TLEM_S_HWM       7
`define TLEM_IRQ_W       3
`define TLEM_SW_PLUS_RST 32'h7FFFFFFF
`define TLEM_SW_MIN_RST  32'h80000000
`endif

// *** common/tlem_pkg.sv ***
// Purpose: shared types of the travel limit monitor
// Assumes: nothing beyond the register header
// Notes: side of entry for soft and hard limits
`default_nettype none
package tlem_pkg;
    typedef enum logic [1:0]
    {
        SIDE_NONE  = 2'b00,
        SIDE_PLUS  = 2'b01,
        SIDE_MINUS = 2'b10
    } tlem_side_t;
endpackage : tlem_pkg
`default_nettype wire

// *** logic/tlem_sync3.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: output rises only when stages two and three both read one and drops when either reads zero; resets to ones
`default_nettype none
module tlem_sync3 #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    // pins and result
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    // stage one feeds stage two only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            // contacts read closed in reset, so no phantom trip gets latched
            s1_r     <= '1;
            s2_r     <= '1;
            s3_r     <= '1;
            sync_out <= '1;
        end
        else if (ce)
        begin
            s1_r     <= pin_in;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            sync_out <= (sync_out & ~(s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
        end
    end
endmodule : tlem_sync3
`default_nettype wire

// *** logic/tlem_monitor.sv ***
// Purpose: soft and hard travel limits plus emergency stop
// Assumes: position inputs on clk_sys; limit and stop pins async
// Notes: pin level 1 means contact closed
`include "tlem_regs.svh"
`default_nettype none
module tlem_monitor
    import tlem_pkg::*;
#(
    parameter int POS_W = 32
) (
    // clock, reset, enable
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             ce,
    // apb slave
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // position loop
    input  wire logic [POS_W-1:0] meas_pos,
    input  wire logic [POS_W-1:0] pos_err,
    // contact pins
    input  wire logic             plus_limit,
    input  wire logic             minus_limit,
    input  wire logic             emergency_stop_in,
    // outputs
    output logic                  plus_entry_flag_out,
    output logic                  minus_entry_flag_out,
    output logic                  sw_limit_warn,
    output logic                  hw_limit_warn,
    output logic                  estop_alarm,
    output logic                  servo_on,
    output logic                  dyn_brake,
    output logic                  move_plus_ok,
    output logic                  move_minus_ok,
    output logic                  irq
);
    logic [`TLEM_CTRL_W-1:0] ctrl_r;
    logic [`TLEM_IRQ_W-1:0]  istat_r;
    logic [`TLEM_IRQ_W-1:0]  imask_r;
    logic [POS_W-1:0]        sw_plus_r;
    logic [POS_W-1:0]        sw_minus_r;
    logic [POS_W-1:0]        cmd_r;
    logic [POS_W-1:0]        hw_pos_r;
    tlem_side_t              sw_side_r;
    tlem_side_t              sw_side_nxt;
    tlem_side_t              hw_side_r;
    tlem_side_t              hw_side_nxt;
    logic                    f4_r;
    logic                    pout_r;
    logic                    mout_r;
    logic [2:0]              pins_s;

    // pin synchronisers
    tlem_sync3 #(.W(3)) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .ce       (ce),
        .pin_in   ({emergency_stop_in, minus_limit, plus_limit}),
        .sync_out (pins_s)
    );

    // contact polarity: 0 is normally closed, so an open wire is active
    wire sdir    = ctrl_r[`TLEM_C_SDIR];
    wire plus_a  = pins_s[0] ^ ~ctrl_r[`TLEM_C_PPOL];  // [R8] [R9] [R5]
    wire minus_a = pins_s[1] ^ ~ctrl_r[`TLEM_C_MPOL];  // [R8] [R9] [R5]
    wire est_a   = pins_s[2] ^ ~ctrl_r[`TLEM_C_EPOL];  // [R15]

    // commanded position; overshoot of meas_pos alone is not seen
    wire [POS_W-1:0] cmd_pos = meas_pos + pos_err;  // [R2] [R3]
    wire sw_over_p = $signed(cmd_pos) > $signed(sw_plus_r);
    wire sw_over_m = $signed(cmd_pos) < $signed(sw_minus_r);
    wire sw_in     = sw_over_p | sw_over_m;  // [R1]

    // entry side held while command stays in the region
    always_comb
    begin
        sw_side_nxt = sw_side_r;
        if (!sw_in)
            sw_side_nxt = SIDE_NONE;  // [R16]
        else if (sw_side_r == SIDE_NONE)
            sw_side_nxt = sw_over_p ? SIDE_PLUS : SIDE_MINUS;  // [R6]
    end

    // scale direction swaps which output opens
    wire pout_nxt = (sw_side_nxt == SIDE_PLUS  && !sdir) ||
                    (sw_side_nxt == SIDE_MINUS &&  sdir);  // [R7]
    wire mout_nxt = (sw_side_nxt == SIDE_MINUS && !sdir) ||
                    (sw_side_nxt == SIDE_PLUS  &&  sdir);  // [R7]

    // hardware latch; released only by opposite motion off the sensor.
    // servo state is not looked at, so hand turning also releases.
    wire hw_rel_p = !plus_a  && $signed(meas_pos) < $signed(hw_pos_r);
    wire hw_rel_m = !minus_a && $signed(meas_pos) > $signed(hw_pos_r);

    always_comb
    begin
        hw_side_nxt = hw_side_r;
        unique case (hw_side_r)
            SIDE_NONE:
            begin
                if (plus_a)
                    hw_side_nxt = SIDE_PLUS;  // [R4]
                else if (minus_a)
                    hw_side_nxt = SIDE_MINUS;  // [R4]
            end
            SIDE_PLUS:
            begin
                // a still active far sensor takes over without a gap
                if (hw_rel_p)
                    hw_side_nxt = minus_a ? SIDE_MINUS : SIDE_NONE;  // [R11] [R12]
            end
            SIDE_MINUS:
            begin
                if (hw_rel_m)
                    hw_side_nxt = plus_a ? SIDE_PLUS : SIDE_NONE;  // [R11] [R12]
            end
            default:
                hw_side_nxt = SIDE_NONE;
        endcase
    end

    // last position seen with the sensor active; release needs motion back past it
    wire hw_track = (hw_side_nxt == SIDE_PLUS  && plus_a) ||
                    (hw_side_nxt == SIDE_MINUS && minus_a);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sw_side_r <= SIDE_NONE;
            hw_side_r <= SIDE_NONE;
            hw_pos_r  <= '0;
            pout_r    <= 1'b0;
            mout_r    <= 1'b0;
            f4_r      <= 1'b0;
            cmd_r     <= '0;
        end
        else if (ce)
        begin
            sw_side_r <= sw_side_nxt;
            hw_side_r <= hw_side_nxt;
            if (hw_track)
                hw_pos_r <= meas_pos;
            pout_r    <= pout_nxt;
            mout_r    <= mout_nxt;
            f4_r      <= est_a;  // [R13] [R14]
            cmd_r     <= cmd_pos;
        end
    end

    // outputs
    assign sw_limit_warn        = sw_side_r != SIDE_NONE;  // [R1]
    assign hw_limit_warn        = hw_side_r != SIDE_NONE;  // [R4]
    assign plus_entry_flag_out  = pout_r;
    assign minus_entry_flag_out = mout_r;
    assign estop_alarm          = f4_r;
    // stop wins over the software servo request
    assign servo_on             = ctrl_r[`TLEM_C_SERVO] && !f4_r;  // [R13]
    assign dyn_brake            = f4_r;  // [R13]
    // only the move back out of the entered side is left open
    assign move_plus_ok  = hw_side_r != SIDE_PLUS;   // [R10]
    assign move_minus_ok = hw_side_r != SIDE_MINUS;  // [R10]

    // interrupt events on rising warnings and on the rising stop alarm
    wire [`TLEM_IRQ_W-1:0] ev = {est_a && !f4_r,
                                 hw_side_nxt != SIDE_NONE && !hw_limit_warn,
                                 sw_in && !sw_limit_warn};

    // apb decode; zero wait states, ce stalls the access phase
    wire acc   = psel && penable && ce;
    wire wr    = acc && pwrite;
    wire a_ctl = paddr == `TLEM_A_CTRL;
    wire a_st  = paddr == `TLEM_A_STATUS;
    wire a_is  = paddr == `TLEM_A_IRQ_STAT;
    wire a_im  = paddr == `TLEM_A_IRQ_MASK;
    wire a_sp  = paddr == `TLEM_A_SW_PLUS;
    wire a_sm  = paddr == `TLEM_A_SW_MINUS;
    wire a_cp  = paddr == `TLEM_A_CMD_POS;
    wire a_ok  = a_ctl | a_st | a_is | a_im | a_sp | a_sm | a_cp;
    wire [`TLEM_IRQ_W-1:0] w1c = (wr && a_is) ? pwdata[`TLEM_IRQ_W-1:0] : '0;

    wire [7:0] status_w = {hw_side_r == SIDE_MINUS, hw_side_r == SIDE_PLUS,
                           servo_on, mout_r, pout_r, f4_r,
                           hw_limit_warn, sw_limit_warn};

    assign pready  = ce;
    assign pslverr = psel && penable && !a_ok;
    assign irq     = |(istat_r & imask_r);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_r     <= `TLEM_CTRL_RST;
            imask_r    <= '0;
            istat_r    <= '0;
            sw_plus_r  <= POS_W'(`TLEM_SW_PLUS_RST);
            sw_minus_r <= POS_W'(`TLEM_SW_MIN_RST);
        end
        else if (ce)
        begin
            // set wins over a clear in the same cycle
            istat_r <= (istat_r & ~w1c) | ev;
            if (wr && a_ctl)
                ctrl_r <= pwdata[`TLEM_CTRL_W-1:0];
            if (wr && a_im)
                imask_r <= pwdata[`TLEM_IRQ_W-1:0];
            if (wr && a_sp)
                sw_plus_r <= pwdata[POS_W-1:0];
            if (wr && a_sm)
                sw_minus_r <= pwdata[POS_W-1:0];
        end
    end

    // read data registered on the setup-phase edge, one edge before access ends
    wire [31:0] rd_w = a_ctl ? {27'h0, ctrl_r} :
                       a_st  ? {24'h0, status_w} :
                       a_is  ? {29'h0, istat_r} :
                       a_im  ? {29'h0, imask_r} :
                       a_sp  ? 32'(sw_plus_r) :
                       a_sm  ? 32'(sw_minus_r) :
                       a_cp  ? 32'(cmd_r) : 32'h0;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prdata <= 32'h0;
        else if (ce && psel && !penable)
            prdata <= rd_w;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_sw_set;
        ce && sw_in |=> sw_limit_warn;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("soft limit not flagged"); // [R1]

    property p_sw_clr;
        ce && !sw_in |=> !sw_limit_warn;
    endproperty
    a_sw_clr: assert property (p_sw_clr) else $error("soft flag without command"); // [R3]

    property p_one_out;
        sw_limit_warn |-> (plus_entry_flag_out ^ minus_entry_flag_out);
    endproperty
    a_one_out: assert property (p_one_out) else $error("not one direction out"); // [R6]

    property p_closed;
        !sw_limit_warn |-> !plus_entry_flag_out && !minus_entry_flag_out;
    endproperty
    a_closed: assert property (p_closed) else $error("direction out open"); // [R16]

    property p_map;
        ce && sw_side_nxt == SIDE_PLUS |=> plus_entry_flag_out == !$past(sdir);
    endproperty
    a_map: assert property (p_map) else $error("direction map wrong"); // [R7]

    property p_estop;
        ce && est_a |=> estop_alarm && !servo_on && dyn_brake;
    endproperty
    a_estop: assert property (p_estop) else $error("stop not applied"); // [R13]

    property p_estop_clr;
        ce && !est_a |=> !estop_alarm && !dyn_brake;
    endproperty
    a_estop_clr: assert property (p_estop_clr) else $error("stop not cleared"); // [R14]

    property p_hold;
        ce && hw_side_r == SIDE_PLUS && !hw_rel_p |=> hw_side_r == SIDE_PLUS;
    endproperty
    a_hold: assert property (p_hold) else $error("hard latch dropped"); // [R11]

    property p_hw_off;
        ce && plus_a && !servo_on |=> hw_limit_warn;
    endproperty
    a_hw_off: assert property (p_hw_off) else $error("hard limit missed"); // [R4]

    property p_exit;
        hw_side_r == SIDE_PLUS |-> move_minus_ok && !move_plus_ok;
    endproperty
    a_exit: assert property (p_exit) else $error("exit motion blocked"); // [R10]
endmodule : tlem_monitor
`default_nettype wire

// *** verification/tlem_field_model.sv ***
// Purpose: limit sensors and stop switch wired to the monitor
// Assumes: contacts normally closed, a loose wire reads 0
// Notes: a hit opens its contact, as a tripped switch does
`default_nettype none
module tlem_field_model (
    // commands from the bench
    input  wire logic wired,
    input  wire logic plus_hit,
    input  wire logic minus_hit,
    input  wire logic stop_hit,
    // contact pins
    output logic      plus_limit,
    output logic      minus_limit,
    output logic      emergency_stop_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // an unplugged cable looks the same as a tripped contact
    assign plus_limit        = wired & ~plus_hit;
    assign minus_limit       = wired & ~minus_hit;
    assign emergency_stop_in = wired & ~stop_hit;
endmodule : tlem_field_model
`default_nettype wire

// *** verification/tb.sv ***
// Purpose: self-checking bench for the travel limit monitor
// Assumes: apb answers with no wait state while ce is high
// Notes: pin effects need about five edges, so waits of ten
`include "tlem_regs.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, meas_pos, pos_err, rd;
    logic        plus_limit, minus_limit, emergency_stop_in, wired, plus_hit, minus_hit, stop_hit;
    logic        pout, mout, sw_w, hw_w, es_a, servo_on, dyn_brake, mp_ok, mm_ok, irq, se;
    int          err_count, tests_run;
    int          cyc_cnt = 0;

    tlem_monitor tlem_monitor_i (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_pos(meas_pos), .pos_err(pos_err), .plus_limit(plus_limit), .minus_limit(minus_limit),
        .emergency_stop_in(emergency_stop_in), .plus_entry_flag_out(pout), .minus_entry_flag_out(mout),
        .sw_limit_warn(sw_w), .hw_limit_warn(hw_w), .estop_alarm(es_a), .servo_on(servo_on),
        .dyn_brake(dyn_brake), .move_plus_ok(mp_ok), .move_minus_ok(mm_ok), .irq(irq));
    tlem_field_model tlem_field_model_i (.wired(wired), .plus_hit(plus_hit), .minus_hit(minus_hit),
        .stop_hit(stop_hit), .plus_limit(plus_limit), .minus_limit(minus_limit),
        .emergency_stop_in(emergency_stop_in));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim

    // a hung handshake would otherwise stall the run forever
    always @(posedge clk_sys)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000)
        begin
            err_count++;
            end_sim();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : wait_n

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // only the cycle ceiling ends a wait that never sees pready
        do
        begin
            @(posedge clk_sys);
        end
        while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic sw_case(input logic [31:0] m, input logic [31:0] e, input logic [2:0] x);
        meas_pos <= m;
        pos_err  <= e;
        wait_n(3);
        chk("sw_warn", x[2], sw_w);
        chk("plus_out", x[1], pout);
        chk("minus_out", x[0], mout);
    endtask : sw_case

    initial
    begin
        {rst, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 43'h0};
        {meas_pos, pos_err, wired, plus_hit, minus_hit, stop_hit} = '0;
        {err_count, tests_run} = '0;
        wait_n(10);
        rst <= 1'b0;
        wait_n(10);
        chk("hw_warn", 1, hw_w);
        chk("estop", 1, es_a);
        chk("brake", 1, dyn_brake);
        chk("servo", 0, servo_on);
        wired <= 1'b1;
        wait_n(10);
        chk("estop", 0, es_a);
        chk("hw_warn", 1, hw_w);
        meas_pos <= 32'hFFFFFFF6;
        wait_n(4);
        chk("hw_warn", 0, hw_w);
        $display("test pins done");
        apb(0, `TLEM_A_SW_PLUS, 0);
        chk("sw_plus", 32'h7FFFFFFF, rd);
        apb(0, `TLEM_A_SW_MINUS, 0);
        chk("sw_minus", 32'h80000000, rd);
        apb(0, 8'h1C, 0);
        chk("slverr", 1, se);
        chk("unmapped", 0, rd);
        apb(1, `TLEM_A_SW_PLUS, 32'h000003E8);
        apb(1, `TLEM_A_SW_MINUS, 32'hFFFFFC18);
        $display("test regs done");
        for (int s = 0; s < 2; s++)
        begin
            apb(1, `TLEM_A_CTRL, 32'h2 | s);
            apb(1, `TLEM_A_IRQ_MASK, s ? 32'h0 : 32'h1);
            sw_case(32'h00000384, 32'h000000C8, s ? 3'b101 : 3'b110);
            chk("irq", !s, irq);
            apb(0, `TLEM_A_STATUS, 0);
            chk("status", s ? 32'h31 : 32'h29, rd);
            apb(0, `TLEM_A_CMD_POS, 0);
            chk("cmd_pos", 32'h44C, rd);
            sw_case(32'h0000044C, 32'hFFFFFF38, 3'b000);
            apb(1, `TLEM_A_IRQ_STAT, 32'h7);
            wait_n(2);
            chk("irq", 0, irq);
            sw_case(32'hFFFFFC7C, 32'hFFFFFF38, s ? 3'b110 : 3'b101);
            sw_case(32'h00000000, 32'h00000000, 3'b000);
        end
        $display("test soft done");
        meas_pos <= 32'h000001F4;
        plus_hit <= 1'b1;
        wait_n(10);
        chk("hw_warn", 1, hw_w);
        chk("plus_ok", 0, mp_ok);
        chk("minus_ok", 1, mm_ok);
        plus_hit <= 1'b0;
        wait_n(10);
        chk("hw_warn", 1, hw_w);
        meas_pos <= 32'h00000190;
        wait_n(4);
        chk("hw_warn", 0, hw_w);
        $display("test hard done");
        ce       <= 1'b0;
        stop_hit <= 1'b1;
        wait_n(10);
        chk("ce_freeze", 0, es_a);
        chk("pready", 0, pready);
        ce <= 1'b1;
        wait_n(10);
        chk("estop", 1, es_a);
        chk("servo", 0, servo_on);
        chk("brake", 1, dyn_brake);
        stop_hit <= 1'b0;
        wait_n(10);
        chk("estop", 0, es_a);
        chk("servo", 1, servo_on);
        $display("test stop done");
        apb(1, `TLEM_A_CTRL, 32'h12);
        wait_n(3);
        chk("estop_no", 1, es_a);
        apb(1, `TLEM_A_CTRL, 32'h2);
        wait_n(3);
        chk("estop_nc", 0, es_a);
        $display("test polarity done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
